// file: hw/ibca_bus_arbiter.sv
// internal bus controller: access timing and cpu / transfer engine arbitration
//
// Behaviour
// - time counted in clock states, one to four
// - memory access one state, 16-bit, byte/word
// - ordinary peripheral access two states, 8/16-bit
// - can module four states plus wait states
// - motor timer, output enable: three states, 16-bit
// - two masters, each with own request
// - acknowledge highest requester; owner keeps bus
// - cpu lowest; transfer engine request wins eventually
// - ownership changes only at cycle boundaries, except when a sleeping cpu hands over
// - sleeping cpu hands over bus immediately
`timescale 1ns/100ps
module ibca_bus_arbiter (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// cpu master
	input  wire logic                       cpu_req,
	input  wire logic                       cpu_start,
	input  wire ibca_pkg::ibca_target_type  cpu_target,
	input  wire logic                       cpu_word,
	input  wire logic                       cpu_periph_wide,
	input  wire logic                       cpu_lock,
	input  wire logic                       cpu_sleep,
	// transfer engine master
	input  wire logic                       te_req,
	input  wire logic                       te_start,
	input  wire ibca_pkg::ibca_target_type  te_target,
	input  wire logic                       te_word,
	input  wire logic                       te_periph_wide,
	input  wire logic                       te_lock,
	// can controller module
	input  wire logic                       can_wait,
	// acknowledges
	output logic                            cpu_ack_reg,
	output logic                            te_ack_reg,
	// access in progress
	output logic                            cyc_busy_reg,
	output logic                            cyc_done_reg,
	output logic [ibca_pkg::STATE_W-1:0]    cyc_state_reg,
	output logic                            cyc_wide_reg,
	output logic                            cyc_word_reg,
	output ibca_pkg::ibca_target_type       cyc_target_reg,
	output ibca_pkg::ibca_owner_type        cyc_master_reg
);
	import ibca_pkg::*;

	ibca_owner_type owner_reg;
	ibca_owner_type owner_next;
	logic lock_reg;
	logic lock_next;

	wire logic boundary;
	wire logic to_engine;
	wire logic to_cpu;
	wire logic cpu_go;
	wire logic te_go;
	wire logic start_any;
	wire logic sel_word;
	wire logic sel_wide;
	wire logic sel_lock;
	wire ibca_target_type sel_target;
	wire ibca_owner_type start_master;

	// boundary: no access running and no multi-part access open
	assign boundary = !cyc_busy_reg && !lock_reg;

	// engine takes the bus at a boundary, or at once while the cpu sleeps
	assign to_engine = cpu_ack_reg && te_req && (boundary || cpu_sleep);
	// engine drops its request only between its operations; cpu gets it back
	assign to_cpu = te_ack_reg && !te_req && boundary;

	// a pending handover blocks new cpu starts so the cpu cannot starve the engine
	assign cpu_go = cpu_ack_reg && cpu_req && cpu_start && !to_engine;
	assign te_go = te_ack_reg && te_req && te_start;
	assign start_any = (cpu_go || te_go) && !cyc_busy_reg;

	// access attributes of the acknowledged master
	assign sel_target = te_ack_reg ? te_target : cpu_target;
	assign sel_word = te_ack_reg ? te_word : cpu_word;
	assign sel_wide = te_ack_reg ? te_periph_wide : cpu_periph_wide;
	assign sel_lock = te_ack_reg ? te_lock : cpu_lock;
	assign start_master = te_ack_reg ? OWN_TE : OWN_CPU;

	always_comb begin
		owner_next = owner_reg;
		case (owner_reg)
			OWN_CPU: begin
				if (to_engine) begin
					owner_next = OWN_TE;
				end
			end
			OWN_TE: begin
				if (to_cpu) begin
					owner_next = OWN_CPU;
				end
			end
			default: begin
				owner_next = OWN_CPU;
			end
		endcase
	end

	// a locked access keeps the bus until its last operation starts
	always_comb begin
		lock_next = lock_reg;
		if (start_any) begin
			lock_next = sel_lock;
		end else if (owner_next != owner_reg) begin
			lock_next = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			owner_reg <= OWN_CPU;
			lock_reg  <= FLAG_RESET;
		end else begin
			owner_reg <= owner_next;
			lock_reg  <= lock_next;
		end
	end

	// acknowledges follow the owner, exactly one at a time
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cpu_ack_reg <= 1'b1;
			te_ack_reg  <= FLAG_RESET;
		end else begin
			cpu_ack_reg <= (owner_next == OWN_CPU);
			te_ack_reg  <= (owner_next == OWN_TE);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cyc_master_reg <= OWN_CPU;
		end else if (start_any) begin
			cyc_master_reg <= start_master;
		end
	end

	// state sequencing lives in the timer so its counts stay in one place
	ibca_cycle_timer i_ibca_cycle_timer (
		.clock       (clock),
		.rst         (rst),
		.start       (start_any),
		.target      (sel_target),
		.word        (sel_word),
		.periph_wide (sel_wide),
		.can_wait    (can_wait),
		.busy_reg    (cyc_busy_reg),
		.done_reg    (cyc_done_reg),
		.state_reg   (cyc_state_reg),
		.wide_reg    (cyc_wide_reg),
		.word_reg    (cyc_word_reg),
		.target_reg  (cyc_target_reg)
	);

	// helper: counts states of the running access, wait states included
	logic [3:0] chk_len_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chk_len_reg <= 4'h0;
		end else if (start_any) begin
			chk_len_reg <= 4'h0;
		end else if (cyc_busy_reg && chk_len_reg != 4'hF) begin
			chk_len_reg <= chk_len_reg + 4'h1;
		end
	end

	a_ack_onehot: assert property (
		@(posedge clock) disable iff (rst) $onehot({cpu_ack_reg, te_ack_reg}))
		else $error("acknowledge not exactly one master");

	a_ack_owner_match: assert property (
		@(posedge clock) disable iff (rst)
		cpu_ack_reg |-> (owner_reg == OWN_CPU) && !te_ack_reg)
		else $error("acknowledge does not match owner");

	sequence s_engine_pending;
		cpu_ack_reg && te_req && !cyc_busy_reg && !lock_reg;
	endsequence

	a_engine_gets_bus: assert property (
		@(posedge clock) disable iff (rst) s_engine_pending |=> te_ack_reg && !cpu_ack_reg)
		else $error("engine request not granted at boundary");

	// a handover edge must not also launch a cpu access
	a_no_cpu_start_pending: assert property (
		@(posedge clock) disable iff (rst) (to_engine && !cyc_busy_reg) |=> !cyc_busy_reg && te_ack_reg)
		else $error("cpu started while handover pending");

	a_cpu_req_gate: assert property (
		@(posedge clock) disable iff (rst) (cpu_ack_reg && !cpu_req && !cyc_busy_reg) |=> !cyc_busy_reg)
		else $error("cpu access started without request");

	a_owner_keeps_bus: assert property (
		@(posedge clock) disable iff (rst) (te_ack_reg && te_req) |=> te_ack_reg)
		else $error("engine lost the bus while requesting");

	a_start_master: assert property (
		@(posedge clock) disable iff (rst)
		$rose(cyc_busy_reg) |-> ((cyc_master_reg == OWN_TE) == $past(te_ack_reg)))
		else $error("access started by a master without acknowledge");

	a_done_single: assert property (
		@(posedge clock) disable iff (rst) cyc_done_reg |=> !cyc_done_reg)
		else $error("done held longer than one cycle");

	a_wide_non_periph: assert property (
		@(posedge clock) disable iff (rst) (start_any && sel_target != TGT_PERIPH) |=> cyc_wide_reg)
		else $error("non peripheral access not on 16-bit path");

	a_handover_boundary: assert property (
		@(posedge clock) disable iff (rst)
		($changed(te_ack_reg) && !$past(cpu_sleep)) |-> $past(!cyc_busy_reg && !lock_reg))
		else $error("ownership changed inside a bus cycle");

	a_sleep_immediate: assert property (
		@(posedge clock) disable iff (rst) (cpu_ack_reg && cpu_sleep && te_req) |=> te_ack_reg)
		else $error("sleeping cpu did not hand over at once");

	a_cpu_default: assert property (
		@(posedge clock) disable iff (rst) (te_ack_reg && !te_req && boundary) |=> cpu_ack_reg)
		else $error("bus not returned to cpu");

	a_mem_path_wide: assert property (
		@(posedge clock) disable iff (rst) (start_any && sel_target == TGT_MEM) |=> cyc_wide_reg)
		else $error("memory access not on 16-bit path");

	a_can_min_states: assert property (
		@(posedge clock) disable iff (rst)
		(start_any && sel_target == TGT_CAN) |=> cyc_busy_reg[*4])
		else $error("can access shorter than four states");

	a_done_length: assert property (
		@(posedge clock) disable iff (rst)
		(cyc_done_reg && cyc_target_reg != TGT_CAN) |->
		(chk_len_reg >= {1'b0, MEM_STATES}) && (chk_len_reg <= {1'b0, MAX_STATES}))
		else $error("access length outside one to four states");

endmodule

// file: hw/ibca_cycle_timer.sv
// access state sequencer: counts the states of one internal bus access
`timescale 1ns/100ps
module ibca_cycle_timer (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// access request from the owning master
	input  wire logic                       start,
	input  wire ibca_pkg::ibca_target_type  target,
	input  wire logic                       word,
	input  wire logic                       periph_wide,
	// wait request from the can controller module
	input  wire logic                       can_wait,
	// access progress
	output logic                            busy_reg,
	output logic                            done_reg,
	output logic [ibca_pkg::STATE_W-1:0]    state_reg,
	output logic                            wide_reg,
	output logic                            word_reg,
	output ibca_pkg::ibca_target_type       target_reg
);
	import ibca_pkg::*;

	logic [STATE_W-1:0] last_reg;

	wire logic [2:0] start_states;
	wire logic [STATE_W-1:0] start_last;
	wire logic start_wide;
	wire logic take;
	wire logic at_last;
	wire logic in_wait;
	wire logic finish;

	// length per target
	assign start_states = (target == TGT_MEM)    ? MEM_STATES :
	                      (target == TGT_PERIPH) ? PERIPH_STATES :
	                      (target == TGT_CAN)    ? CAN_STATES :
	                                               MOTOR_STATES;
	assign start_last = start_states[STATE_W-1:0] - 2'h1;
	// only ordinary peripherals may use the narrow path
	assign start_wide = (target == TGT_PERIPH) ? periph_wide : PATH_16;
	assign take = start && !busy_reg;
	assign at_last = busy_reg && (state_reg == last_reg);
	// wait states hold the final state as long as the module asks
	assign in_wait = at_last && (target_reg == TGT_CAN) && can_wait;
	assign finish = at_last && !in_wait;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_reg   <= FLAG_RESET;
			done_reg   <= FLAG_RESET;
			state_reg  <= STATE_RESET;
			last_reg   <= STATE_RESET;
			wide_reg   <= PATH_16;
			word_reg   <= FLAG_RESET;
			target_reg <= TGT_MEM;
		end else begin
			done_reg <= finish;
			if (take) begin
				busy_reg   <= 1'b1;
				state_reg  <= STATE_RESET;
				last_reg   <= start_last;
				wide_reg   <= start_wide;
				word_reg   <= word;
				target_reg <= target;
			end else if (finish) begin
				busy_reg <= 1'b0;
			end else if (busy_reg && !in_wait) begin
				state_reg <= state_reg + 2'h1;
			end
		end
	end

	a_state_count_bound: assert property (
		@(posedge clock) disable iff (rst) busy_reg |-> (state_reg <= last_reg) && (last_reg <= 2'h3))
		else $error("access exceeds four states");

	sequence s_one_state;
		busy_reg ##1 (done_reg && !busy_reg);
	endsequence

	a_mem_one_state: assert property (
		@(posedge clock) disable iff (rst) (take && target == TGT_MEM) |=> s_one_state)
		else $error("memory access not one state");

	a_periph_two_states: assert property (
		@(posedge clock) disable iff (rst) (take && target == TGT_PERIPH) |=> busy_reg[*2] ##1 done_reg)
		else $error("peripheral access not two states");

	a_motor_three_states: assert property (
		@(posedge clock) disable iff (rst)
		(take && target == TGT_MOTOR) |=> (busy_reg && wide_reg)[*3] ##1 done_reg)
		else $error("motor or output enable access not three states");

	a_can_wait_hold: assert property (
		@(posedge clock) disable iff (rst) in_wait |=> busy_reg && !done_reg && $stable(state_reg))
		else $error("can wait request not honoured");

endmodule

// file: hw/ibca_pkg.sv
// shared constants and types of the internal bus controller and arbiter
package ibca_pkg;

	// access targets on the internal bus
	typedef enum logic [1:0] {
		TGT_MEM,
		TGT_PERIPH,
		TGT_CAN,
		TGT_MOTOR
	} ibca_target_type;

	// current bus owner
	typedef enum logic {
		OWN_CPU,
		OWN_TE
	} ibca_owner_type;

	// states per access, one state is one clock period
	localparam logic [2:0] MEM_STATES    = 3'h1;
	localparam logic [2:0] PERIPH_STATES = 3'h2;
	localparam logic [2:0] CAN_STATES    = 3'h4;
	localparam logic [2:0] MOTOR_STATES  = 3'h3;
	localparam logic [2:0] MAX_STATES    = 3'h4;

	// state counter width and reset values
	localparam int         STATE_W       = 2;
	localparam logic [1:0] STATE_RESET   = 2'h0;
	localparam logic       FLAG_RESET    = 1'h0;

	// data path width flag: high means 16 bits, low means 8 bits
	localparam logic       PATH_16       = 1'h1;
	localparam logic       PATH_8        = 1'h0;

endpackage

// file: verification/ibca_bus_arbiter_bench.sv
// self-checking bench of the bus controller and arbiter
`timescale 1ns/100ps
module ibca_bus_arbiter_bench;
	import ibca_pkg::*;
	logic            clock, rst, cpu_start, cpu_word, cpu_periph_wide, cpu_lock, cpu_sleep, can_wait, go;
	logic            te_req, te_start, cpu_ack_reg, te_ack_reg, cyc_busy_reg, cyc_done_reg, cpu_req;
	logic            cyc_wide_reg, cyc_word_reg;
	logic [1:0]      cyc_state_reg;
	ibca_target_type cpu_target, te_target, cyc_target_reg;
	ibca_owner_type  cyc_master_reg;
	int              ops, n_mismatch, n_compared;

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// engine side sizes and lock are not exercised by the model
	ibca_bus_arbiter i_ibca_bus_arbiter (.clock, .rst, .cpu_req, .cpu_start, .cpu_target, .cpu_word,
		.cpu_periph_wide, .cpu_lock, .cpu_sleep, .te_req, .te_start, .te_target, .te_word(1'b0),
		.te_periph_wide(1'b1), .te_lock(1'b0), .can_wait, .cpu_ack_reg, .te_ack_reg, .cyc_busy_reg,
		.cyc_done_reg, .cyc_state_reg, .cyc_wide_reg, .cyc_word_reg, .cyc_target_reg, .cyc_master_reg);

	ibca_te_model i_ibca_te_model (.clock, .go, .te_req, .te_start, .te_target, .te_ack_reg,
		.cyc_busy_reg, .cyc_done_reg, .cyc_master_reg, .ops);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one cpu access; nw wait states asked for in the final state
	task automatic acc(input ibca_target_type t, input logic w, input int nw, input int ns);
		int n;
		int k;
		n = 1;
		k = 0;
		cpu_start = 1'b1;
		cpu_target = t;
		cpu_periph_wide = w;
		cpu_word = w;
		@(negedge clock);
		cpu_start = 1'b0;
		chk(8'(cyc_state_reg), 8'h0);
		chk(8'(cyc_target_reg), 8'(t));
		while (cyc_done_reg !== 1'b1 && n < 20) begin
			can_wait = (cyc_state_reg === 2'h3 && k < nw);
			if (can_wait)
				k++;
			@(negedge clock);
			n++;
		end
		can_wait = 1'b0;
		chk(8'(n), 8'(ns + nw + 1));
		chk(8'(cyc_wide_reg), 8'((t == TGT_PERIPH) ? w : PATH_16));
		chk(8'(cyc_word_reg), 8'(w));
		chk(8'(cyc_master_reg), 8'(OWN_CPU));
	endtask

	task automatic wte(input logic v);
		int n;
		n = 0;
		while (te_ack_reg !== v && n < 30) begin
			@(negedge clock);
			n++;
		end
		chk(8'(te_ack_reg), 8'(v));
		chk(8'(cpu_ack_reg), 8'(!v));
	endtask

	task automatic pulse;
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
	endtask

	task automatic t_time;
		chk(8'(cpu_ack_reg), 8'h1);
		chk(8'(cyc_busy_reg), 8'h0);
		// a start without request is ignored
		cpu_req = 1'b0;
		cpu_start = 1'b1;
		@(negedge clock);
		chk(8'(cyc_busy_reg), 8'h0);
		cpu_req = 1'b1;
		acc(TGT_MEM, 1'b0, 0, 1);
		acc(TGT_PERIPH, PATH_8, 0, 2);
		acc(TGT_PERIPH, PATH_16, 0, 2);
		acc(TGT_MOTOR, 1'b1, 0, 3);
		acc(TGT_CAN, 1'b1, 0, 4);
		acc(TGT_CAN, 1'b1, 2, 4);
	endtask

	// engine asks during a long cpu access: waits for its end
	task automatic t_defer;
		cpu_start = 1'b1;
		cpu_target = TGT_CAN;
		@(negedge clock);
		cpu_start = 1'b0;
		pulse();
		while (cyc_busy_reg === 1'b1) begin
			chk(8'(te_ack_reg), 8'h0);
			@(negedge clock);
		end
		wte(1'b1);
		wte(1'b0);
		chk(8'(ops), 8'h1);
	endtask

	task automatic t_lock;
		cpu_lock = 1'b1;
		acc(TGT_MEM, 1'b1, 0, 1);
		pulse();
		repeat (5) begin
			chk(8'(te_ack_reg), 8'h0);
			@(negedge clock);
		end
		cpu_lock = 1'b0;
		acc(TGT_MEM, 1'b1, 0, 1);
		wte(1'b1);
		wte(1'b0);
		chk(8'(ops), 8'h2);
	endtask

	task automatic t_sleep;
		cpu_start = 1'b1;
		cpu_target = TGT_CAN;
		@(negedge clock);
		cpu_start = 1'b0;
		cpu_sleep = 1'b1;
		pulse();
		@(negedge clock);
		chk(8'(te_ack_reg), 8'h1);
		chk(8'(cyc_busy_reg), 8'h1);
		wte(1'b0);
		cpu_sleep = 1'b0;
		chk(8'(ops), 8'h3);
	endtask

	initial begin
		n_mismatch = 0;
		n_compared = 0;
		{cpu_start, cpu_word, cpu_periph_wide, cpu_lock, cpu_sleep, can_wait, go} = 7'h00;
		cpu_target = TGT_MEM;
		cpu_req = 1'b1;
		rst = 1'b1;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_time();
		t_defer();
		t_lock();
		t_sleep();
		close_out();
	end

	// the whole run needs well under two thousand cycles
	initial begin
		#20000;
		n_mismatch++;
		close_out();
	end
endmodule

// file: verification/ibca_te_model.sv
// transfer engine master model: one memory transfer per go pulse
`timescale 1ns/100ps
module ibca_te_model (
	// clock and command
	input  wire logic                      clock,
	input  wire logic                      go,
	// master side of the arbiter
	output logic                           te_req,
	output logic                           te_start,
	output ibca_pkg::ibca_target_type      te_target,
	input  wire logic                      te_ack_reg,
	input  wire logic                      cyc_busy_reg,
	input  wire logic                      cyc_done_reg,
	input  wire ibca_pkg::ibca_owner_type  cyc_master_reg,
	// completed transfers
	output int                             ops
);
	import ibca_pkg::*;
	int n;
	initial begin
		te_req = 1'b0;
		te_start = 1'b0;
		te_target = TGT_MEM;
		ops = 0;
		forever begin
			@(posedge clock);
			if (go) begin
				@(negedge clock);
				te_req = 1'b1;
				n = 0;
				while (te_ack_reg !== 1'b1 && n < 40) begin
					@(negedge clock);
					n++;
				end
				te_start = 1'b1;
				// a sleeping cpu may still finish its access first
				do begin
					@(negedge clock);
					n++;
				end while (!(cyc_busy_reg === 1'b1 && cyc_master_reg === OWN_TE) && n < 80);
				te_start = 1'b0;
				while (cyc_done_reg !== 1'b1 && n < 120) begin
					@(negedge clock);
					n++;
				end
				te_req = 1'b0;
				ops++;
			end
		end
	end
endmodule
